// ===== design/spi_pm_pkg.sv
package spi_pm_pkg;
	localparam logic [5:0] ADDR_INACT_THRESH = 6'h25;
	localparam logic [5:0] ADDR_INACT_TIME = 6'h26;
	localparam logic [5:0] ADDR_RATE_POWER = 6'h2c;
	localparam logic [5:0] ADDR_POWER_CONTROL = 6'h2d;
	localparam logic [5:0] ADDR_FORMAT = 6'h31;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int RATE_LSB = 0;
	localparam int LOW_POWER_BIT = 4;
	localparam int MEASURE_BIT = 3;
	localparam int AUTO_SLEEP_BIT = 4;
	localparam int LINK_BIT = 5;
	localparam int THREE_WIRE_BIT = 6;
	localparam int CMD_READ_BIT = 7;
	localparam int CMD_BURST_BIT = 6;
	localparam logic [3:0] RATE_TOP_CODE = 4'hf;
	localparam logic [3:0] SLEEP_RATE_CODE = 4'h6;
	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TOP_RATE_HZ = 3200;
	localparam int BASE_PERIOD_CYC = CLK_HZ / TOP_RATE_HZ;
	localparam int SCLK_MAX_HZ = 5_000_000;
	localparam int SCLK_MIN_HALF_CYC = (CLK_HZ / (2 * SCLK_MAX_HZ)) < 1 ? 1 : CLK_HZ / (2 * SCLK_MAX_HZ);
	localparam int SCLK_HALF_CYC = 8;
	localparam int CS_GAP_NS = 150;
	localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_WDATA = 12'h004;
	localparam logic [11:0] OFS_RDATA = 12'h008;
	localparam logic [11:0] OFS_STATUS = 12'h00c;
	localparam int CTRL_ADDR_LSB = 0;
	localparam int CTRL_READ_BIT = 6;
	localparam int CTRL_BURST_BIT = 7;
	localparam int CTRL_LEN_LSB = 8;
	localparam int CTRL_3W_BIT = 10;
	localparam int CTRL_START_BIT = 31;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_LEAD = 5'b00010,
		H_LOW = 5'b00100,
		H_HIGH = 5'b01000,
		H_GAP = 5'b10000
	} host_state_e;
endpackage

// ===== design/spi_pm_link.sv
`timescale 1ns/100ps
interface spi_pm_link;
	logic cs_b;
	logic sclk;
	logic host_sdio_out;
	logic host_sdio_oe;
	logic dev_sdio_out;
	logic dev_sdio_oe;
	logic dev_sdo_out;
	logic dev_sdo_oe;
	logic sdio;
	logic sdo;
	// undriven lines read high, as with a pull-up
	assign sdio = host_sdio_oe ? host_sdio_out : (dev_sdio_oe ? dev_sdio_out : 1'b1);
	assign sdo = dev_sdo_oe ? dev_sdo_out : 1'b1;
	modport device (input cs_b, input sclk, input sdio, output dev_sdio_out, output dev_sdio_oe,
		output dev_sdo_out, output dev_sdo_oe);
	modport host (output cs_b, output sclk, output host_sdio_out, output host_sdio_oe, input sdio, input sdo);
endinterface

// ===== design/spi_pm_device.sv
// Added by the designer: register access over the 3- or 4-wire serial link.
`timescale 1ns/100ps
module spi_pm_device
	import spi_pm_pkg::*;
#(
	parameter int BASE_PERIOD = BASE_PERIOD_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	spi_pm_link.device link,
	input wire logic sample_quiet,
	output logic measuring,
	output logic asleep,
	output logic reduced_sampling,
	output logic [3:0] active_rate_code,
	output logic sample_tick,
	output logic [7:0] quiet_threshold,
	output logic i2c_selected
);
	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic ck_s1;
		logic ck_s2;
		logic ck_d;
		logic di_s1;
		logic di_s2;
		logic [2:0] bitcnt;
		logic hdr;
		logic rw;
		logic mb;
		logic stop;
		logic [5:0] ptr;
		logic [7:0] sh;
		logic [7:0] tx;
		logic dout;
		logic oe;
		logic seen_cs;
		logic [63:0][7:0] regs;
		logic [31:0] tick_cnt;
		logic tick;
		logic [7:0] quiet_cnt;
		logic asleep;
		logic [3:0] rate_code;
		logic low_power;
	} dev_s;

	dev_s s;
	dev_s next_s;
	// clock detector starts at idle high, so reset makes no false edge
	localparam dev_s DEV_RESET = '{cs_s1: 1'b1, cs_s2: 1'b1, ck_s1: 1'b1, ck_s2: 1'b1, ck_d: 1'b1,
		di_s1: 1'b1, di_s2: 1'b1, dout: 1'b1, regs: {64{REG_RESET}}, default: '0};

	// period doubles for each code step below the top code
	function automatic logic [31:0] rate_period(input logic [3:0] code);
		rate_period = 32'(BASE_PERIOD) << (RATE_TOP_CODE - code);
	endfunction

	function automatic logic measure_on(input logic [63:0][7:0] r);
		measure_on = r[ADDR_POWER_CONTROL][MEASURE_BIT];
	endfunction

	// sleep overrides the programmed code so the timer slows at once
	function automatic logic [3:0] pick_code(input logic [63:0][7:0] r, input logic sleeping);
		pick_code = sleeping ? SLEEP_RATE_CODE : r[ADDR_RATE_POWER][RATE_LSB +: 4];
	endfunction

	logic rise;
	logic fall;
	logic selected;
	logic [7:0] in_byte;
	logic [3:0] code;
	logic sleep_armed;
	logic three_wire;

	always_comb begin
		next_s = s;
		// edges come only from the second stage, never the first
		rise = s.ck_s2 & ~s.ck_d;
		fall = ~s.ck_s2 & s.ck_d;
		selected = ~s.cs_s2;
		in_byte = {s.sh[6:0], s.di_s2};
		three_wire = s.regs[ADDR_FORMAT][THREE_WIRE_BIT];
		sleep_armed = s.regs[ADDR_POWER_CONTROL][AUTO_SLEEP_BIT] & s.regs[ADDR_POWER_CONTROL][LINK_BIT];
		code = s.rate_code;
		// pins are asynchronous to clk, two stages each
		next_s.cs_s1 = link.cs_b;
		next_s.cs_s2 = s.cs_s1;
		next_s.ck_s1 = link.sclk;
		next_s.ck_s2 = s.ck_s1;
		next_s.ck_d = s.ck_s2;
		next_s.di_s1 = link.sdio;
		next_s.di_s2 = s.di_s1;
		if (!selected) begin
			// chip select high ends the frame and drops the header state; the pointer keeps its value
			next_s.bitcnt = '0;
			next_s.hdr = 1'b0;
			next_s.stop = 1'b0;
			next_s.oe = 1'b0;
		end else begin
			next_s.seen_cs = 1'b1;
			if (rise && !s.stop) begin
				next_s.sh = in_byte;
				next_s.bitcnt = s.bitcnt + 3'd1;
				if (s.bitcnt == 3'd7) begin
					if (!s.hdr) begin
						next_s.hdr = 1'b1;
						next_s.rw = in_byte[CMD_READ_BIT];
						next_s.mb = in_byte[CMD_BURST_BIT];
						next_s.ptr = in_byte[5:0];
						next_s.tx = s.regs[in_byte[5:0]];
					end else begin
						// every register answers in standby as well
						// a write lands on the eighth rise of its byte
						if (!s.rw) begin
							next_s.regs[s.ptr] = in_byte;
						end
						next_s.ptr = s.ptr + 6'd1;
						// next byte fetched at byte end; pointer wraps at 63
						next_s.tx = s.regs[6'(s.ptr + 6'd1)];
						if (!s.mb) begin
							next_s.stop = 1'b1;
							next_s.oe = 1'b0;
						end
					end
				end
			end
			if (fall && s.hdr && s.rw && !s.stop) begin
				next_s.dout = s.tx[7];
				next_s.tx = {s.tx[6:0], 1'b0};
				next_s.oe = 1'b1;
			end
		end
		// rate timer; a shorter code cuts the running period short
		next_s.tick = 1'b0;
		if (!measure_on(s.regs)) begin
			// standby stops new samples and clears the sleep state and the quiet count
			next_s.tick_cnt = '0;
			next_s.asleep = 1'b0;
			next_s.quiet_cnt = '0;
		end else if (s.tick_cnt >= rate_period(code) - 32'd1) begin
			next_s.tick_cnt = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.tick_cnt = s.tick_cnt + 32'd1;
		end
		if (s.tick) begin
			// any busy tick wakes, so motion is never sampled slowly for long
			if (!sleep_armed || !sample_quiet) begin
				next_s.quiet_cnt = '0;
				next_s.asleep = 1'b0;
			end else if (s.quiet_cnt >= s.regs[ADDR_INACT_TIME] && s.regs[ADDR_INACT_TIME] != 8'h00) begin
				next_s.asleep = 1'b1;
			end else begin
				next_s.quiet_cnt = s.quiet_cnt + 8'd1;
			end
		end
		// outputs registered so they never glitch on a register write
		next_s.rate_code = pick_code(next_s.regs, next_s.asleep);
		next_s.low_power = next_s.regs[ADDR_RATE_POWER][LOW_POWER_BIT] & measure_on(next_s.regs);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= DEV_RESET;
		end else begin
			s <= next_s;
		end
	end

	// 4-wire output floats outside read data as well
	assign link.dev_sdo_out = s.dout;
	assign link.dev_sdo_oe = s.oe & ~three_wire;
	assign link.dev_sdio_out = s.dout;
	assign link.dev_sdio_oe = s.oe & three_wire;
	assign measuring = s.regs[ADDR_POWER_CONTROL][MEASURE_BIT];
	assign asleep = s.asleep;
	assign reduced_sampling = s.low_power;
	assign active_rate_code = s.rate_code;
	assign sample_tick = s.tick;
	assign quiet_threshold = s.regs[ADDR_INACT_THRESH];
	// no two-wire engine here; the flag only reports that chip select has not gone low since reset
	assign i2c_selected = ~s.seen_cs;
endmodule

// ===== design/spi_pm_host.sv
`timescale 1ns/100ps
module spi_pm_host
	import spi_pm_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	spi_pm_link.host link
);
	typedef struct packed {
		host_state_e st;
		logic [7:0] cnt;
		logic [5:0] bitno;
		logic [5:0] total;
		logic [39:0] sh;
		logic [31:0] rx;
		logic [31:0] ctrl;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic sclk;
		logic cs_b;
		logic mosi;
		logic mosi_oe;
		logic busy;
		logic done;
		logic in_s1;
		logic in_s2;
	} host_s;

	host_s s;
	host_s next_s;
	localparam host_s HOST_RESET = '{st: H_IDLE, sclk: 1'b1, cs_b: 1'b1, mosi: 1'b1, mosi_oe: 1'b1,
		default: '0};
	localparam logic [7:0] HALF_LAST = 8'(((HALF_CYC < SCLK_MIN_HALF_CYC) ? SCLK_MIN_HALF_CYC : HALF_CYC) - 1);
	localparam logic [7:0] GAP_LAST = 8'(CS_GAP_CYC - 1);

	logic wr;
	logic access;
	logic mapped;
	logic is_read;
	logic three_wire;

	always_comb begin
		next_s = s;
		access = psel & penable;
		wr = access & pwrite;
		mapped = paddr == OFS_CTRL || paddr == OFS_WDATA || paddr == OFS_RDATA || paddr == OFS_STATUS;
		is_read = s.ctrl[CTRL_READ_BIT];
		three_wire = s.ctrl[CTRL_3W_BIT];
		next_s.in_s1 = three_wire ? link.sdio : link.sdo;
		next_s.in_s2 = s.in_s1;
		if (wr && paddr == OFS_WDATA) begin
			next_s.wdata = pwdata;
		end
		if (wr && paddr == OFS_STATUS && pwdata[STATUS_DONE_BIT]) begin
			next_s.done = 1'b0;
		end
		next_s.cnt = s.cnt - 8'd1;
		case (s.st)
			H_IDLE: begin
				// each command is its own frame; scattered registers take several
				if (wr && paddr == OFS_CTRL && pwdata[CTRL_START_BIT]) begin
					next_s.ctrl = pwdata;
					next_s.busy = 1'b1;
					next_s.cs_b = 1'b0;
					next_s.mosi_oe = 1'b1;
					next_s.sh = {pwdata[CTRL_READ_BIT], pwdata[CTRL_BURST_BIT], pwdata[CTRL_ADDR_LSB +: 6],
						s.wdata[7:0], s.wdata[15:8], s.wdata[23:16], s.wdata[31:24]};
					next_s.total = {1'b0, pwdata[CTRL_LEN_LSB +: 2], 3'b000} + 6'd16;
					next_s.bitno = '0;
					next_s.rx = '0;
					next_s.cnt = HALF_LAST;
					next_s.st = H_LEAD;
				end
			end
			H_LEAD: begin
				if (s.cnt == 8'd0) begin
					next_s.st = H_LOW;
				end
			end
			H_LOW: begin
				if (s.cnt == 8'd0 || s.sclk) begin
					if (s.sclk) begin
						// outgoing bit changes on the falling edge
						next_s.sclk = 1'b0;
						next_s.mosi = s.sh[39];
						next_s.sh = {s.sh[38:0], 1'b0};
						next_s.mosi_oe = !(three_wire && is_read && s.bitno >= 6'd8);
						next_s.cnt = HALF_LAST;
					end else begin
						next_s.st = H_HIGH;
						next_s.sclk = 1'b1;
						next_s.cnt = HALF_LAST;
						// returned bits kept only for reads
						if (is_read && s.bitno >= 6'd8) begin
							next_s.rx = {s.rx[30:0], s.in_s2};
						end
					end
				end
			end
			H_HIGH: begin
				if (s.cnt == 8'd0) begin
					next_s.bitno = s.bitno + 6'd1;
					if (s.bitno + 6'd1 == s.total) begin
						next_s.cs_b = 1'b1;
						// shared line stays released until the next frame; the device lets go late
						next_s.cnt = GAP_LAST;
						next_s.st = H_GAP;
					end else begin
						next_s.st = H_LOW;
					end
				end
			end
			H_GAP: begin
				if (s.cnt == 8'd0) begin
					next_s.busy = 1'b0;
					next_s.done = 1'b1;
					next_s.rdata = s.rx;
					next_s.st = H_IDLE;
				end
			end
			default: begin
				next_s = HOST_RESET;
			end
		endcase
		prdata = '0;
		case (paddr)
			OFS_CTRL: prdata = s.ctrl;
			OFS_WDATA: prdata = s.wdata;
			OFS_RDATA: prdata = s.rdata;
			OFS_STATUS: prdata = {30'd0, s.done, s.busy};
			default: prdata = '0;
		endcase
	end

	// chip select high from reset covers a clock-mode change before first use
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= HOST_RESET;
		end else begin
			s <= next_s;
		end
	end

	// rate/low-power pairing and bus speed per rate are left to software
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign link.cs_b = s.cs_b;
	assign link.sclk = s.sclk;
	assign link.host_sdio_out = s.mosi;
	assign link.host_sdio_oe = s.mosi_oe;
endmodule

// ===== verif/spi_pm_link_assertions.sv
`timescale 1ns/100ps
module spi_pm_link_assertions (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic cs_b,
	input wire logic sclk,
	input wire logic host_sdio_oe,
	input wire logic dev_sdio_oe,
	input wire logic dev_sdo_oe,
	input wire logic dev_sdio_out,
	input wire logic dev_sdo_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_SCLK_IDLE: assert property (cs_b |-> sclk) else $error("sclk low outside frame");
	AST_CS_LEAD: assert property ($fell(cs_b) |-> sclk [*8]) else $error("short lead");
	AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*4] ##[1:12] sclk) else $error("bad low phase");
	AST_SCLK_HIGH: assert property ($rose(sclk) && !cs_b |-> sclk [*4]) else $error("short high phase");
	AST_CS_GAP: assert property ($rose(cs_b) |-> cs_b [*2]) else $error("short frame gap");
	AST_NO_CLASH: assert property (!(host_sdio_oe && dev_sdio_oe)) else $error("shared line clash");
	AST_HEADER_QUIET: assert property ($fell(cs_b) |-> !(dev_sdo_oe || dev_sdio_oe) [*8]) else $error("early drive");
	AST_RELEASE: assert property ($rose(cs_b) |-> ##4 !(dev_sdo_oe || dev_sdio_oe)) else $error("no release");
	AST_SDO_HOLD: assert property (sclk && $past(sclk) && dev_sdo_oe && $past(dev_sdo_oe) |-> $stable(dev_sdo_out))
		else $error("sdo moved while sclk high");
	AST_SDIO_HOLD: assert property (sclk && $past(sclk) && dev_sdio_oe && $past(dev_sdio_oe) |-> $stable(dev_sdio_out))
		else $error("sdio moved while sclk high");
endmodule

// ===== verif/testbench.sv
`timescale 1ns/100ps
module testbench;
	import spi_pm_pkg::*;
	logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, sample_quiet = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r, t, m;
	logic pready, pslverr, measuring, asleep, reduced_sampling, sample_tick, i2c_selected;
	logic [3:0] active_rate_code;
	logic [7:0] quiet_threshold, thr, tim;
	logic [31:0] eq[$], mq[$];
	int n_errors = 0, n_tests = 0, cyc = 0, nt = 0, t0;
	spi_pm_link link();
	always #50 clk = ~clk;
	spi_pm_host #(.HALF_CYC(8)) spi_pm_host_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(link));
	spi_pm_device #(.BASE_PERIOD(4)) spi_pm_device_inst (.clk(clk), .rst_b(rst_b), .link(link),
		.sample_quiet(sample_quiet), .measuring(measuring), .asleep(asleep), .reduced_sampling(reduced_sampling),
		.active_rate_code(active_rate_code), .sample_tick(sample_tick), .quiet_threshold(quiet_threshold),
		.i2c_selected(i2c_selected));
	spi_pm_link_assertions spi_pm_link_assertions_inst (.clk(clk), .rst_b(rst_b), .cs_b(link.cs_b), .sclk(link.sclk),
		.host_sdio_oe(link.host_sdio_oe), .dev_sdio_oe(link.dev_sdio_oe), .dev_sdo_oe(link.dev_sdo_oe),
		.dev_sdio_out(link.dev_sdio_out), .dev_sdo_out(link.dev_sdo_out));
	task close_out;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	// expected read notes are queued before the access; the watcher below consumes them
	task spi(input logic [5:0] a, input logic rd, bst, input logic [1:0] len, input logic tw,
		input logic [31:0] wd, exp, msk);
		apb(1, OFS_WDATA, wd, r);
		apb(1, OFS_CTRL, {1'b1, 20'h0, tw, len, bst, rd, a}, r);
		do apb(0, OFS_STATUS, 32'h0, r); while (r[STATUS_DONE_BIT] !== 1'b1);
		apb(1, OFS_STATUS, 32'h2, r);
		if (rd) begin
			eq.push_back(exp);
			mq.push_back(msk);
			apb(0, OFS_RDATA, 32'h0, r);
		end
	endtask
	task wt;
		@(posedge clk);
		while (sample_tick !== 1'b1) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (sample_tick === 1'b1)
			nt <= nt + 1;
		if (cyc == 60000) begin
			n_errors++;
			close_out;
		end
	end
	always @(posedge clk) if (psel && penable && pready && !pwrite && (paddr == OFS_RDATA || paddr == 12'h010)) begin
		if (eq.size() == 0)
			chk("note", 32'h0, 32'h1);
		else begin
			t = eq.pop_front();
			m = mq.pop_front();
			chk("rdata", t, prdata & m);
		end
		if (paddr == 12'h010)
			chk("pslverr", 32'h1, {31'h0, pslverr});
	end
	initial begin
		void'($urandom(63));
		thr = 8'($urandom);
		tim = 8'($urandom);
		repeat (3) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		chk("i2c_sel", 32'h1, {31'h0, i2c_selected});
		chk("measuring", 32'h0, {31'h0, measuring});
		spi(ADDR_INACT_THRESH, 0, 1, 2'd1, 0, {16'h0, tim, thr}, 32'h0, 32'h0);
		chk("threshold", {24'h0, thr}, {24'h0, quiet_threshold});
		chk("i2c_sel", 32'h0, {31'h0, i2c_selected});
		spi(ADDR_INACT_THRESH, 1, 1, 2'd1, 0, 32'h0, {16'h0, thr, tim}, 32'hffff);
		spi(ADDR_INACT_THRESH, 1, 0, 2'd0, 0, 32'h0, {24'h0, thr}, 32'hff);
		eq.push_back(32'h0);
		mq.push_back(32'hffffffff);
		apb(0, 12'h010, 32'h0, r);
		spi(ADDR_POWER_CONTROL, 0, 0, 2'd0, 0, 32'h08, 32'h0, 32'h0);
		chk("measuring", 32'h1, {31'h0, measuring});
		// count between later ticks, the first may still run on the old period
		for (int c = 15; c >= 12; c--) begin
			spi(ADDR_RATE_POWER, 0, 0, 2'd0, 0, c, 32'h0, 32'h0);
			wt;
			wt;
			t0 = cyc;
			wt;
			chk("tick_period", 4 << (15 - c), cyc - t0);
		end
		spi(ADDR_RATE_POWER, 0, 0, 2'd0, 0, 32'h1a, 32'h0, 32'h0);
		chk("low_power", 32'h1, {31'h0, reduced_sampling});
		spi(ADDR_FORMAT, 0, 0, 2'd0, 0, 32'h40, 32'h0, 32'h0);
		spi(ADDR_FORMAT, 1, 0, 2'd0, 1, 32'h0, 32'h40, 32'hff);
		spi(ADDR_INACT_TIME, 0, 0, 2'd0, 1, 32'h2, 32'h0, 32'h0);
		spi(ADDR_POWER_CONTROL, 0, 0, 2'd0, 1, 32'h38, 32'h0, 32'h0);
		sample_quiet <= 1;
		while (asleep !== 1'b1) @(posedge clk);
		chk("sleep_rate", 32'h6, {28'h0, active_rate_code});
		sample_quiet <= 0;
		while (asleep !== 1'b0) @(posedge clk);
		chk("wake_rate", 32'ha, {28'h0, active_rate_code});
		spi(ADDR_POWER_CONTROL, 0, 0, 2'd0, 1, 32'h30, 32'h0, 32'h0);
		chk("standby", 32'h0, {30'h0, measuring, asleep});
		t0 = nt;
		repeat (300) @(posedge clk);
		chk("no_ticks", t0, nt);
		spi(ADDR_RATE_POWER, 1, 0, 2'd0, 1, 32'h0, 32'h1a, 32'hff);
		close_out;
	end
endmodule
